// [rtl/pdwl_lock.sv]
// Disable register bank guarded by a lock bit in the configuration control register.
// Assumes the unlock sequence detector lives elsewhere and gives a level UNLOCKED_I.
`timescale 1ns/1ps
`include "pdwl_defines.svh"
module pdwl_lock (
    input  wire logic                                        CLK_I,
    input  wire logic                                        RST_I,
    input  wire logic                                        CE_I,
    input  wire logic [31:0]                                 CFG_WORD3_I,
    input  wire logic                                        UNLOCKED_I,
    input  wire logic                                        CFG_WR_I,
    input  wire logic [31:0]                                 CFG_WDATA_I,
    input  wire pdwl_pkg::pdwl_wr_t                          DIS_WR_I,
    output logic                                             DIS_ACK_O,
    output logic [`PDWL_NUM_REGS-1:0][`PDWL_DATA_W-1:0]      DIS_REGS_O,
    output logic                                             LOCK_O,
    output logic                                             ONE_WAY_HELD_O
);
    import pdwl_pkg::*;

    pdwl_state_t s_q;
    pdwl_state_t s_d;
    logic        one_way;
    logic        lock_req;
    logic        lock_chg_ok;
    logic        lock_pinned;

    // Lock field of a config control word; the checks below use it as well
    function automatic logic lock_field(input logic [31:0] word);
        return word[`PDWL_LOCK_BIT];
    endfunction

    assign one_way  = CFG_WORD3_I[`PDWL_ONE_WAY_BIT];
    assign lock_req = lock_field(CFG_WDATA_I);

    // Clearing is barred once armed; setting an already-set lock changes nothing.
    assign lock_chg_ok = CFG_WR_I && UNLOCKED_I && !s_q.one_way_armed;

    // One-way mode may turn on while the lock is already set; a clear in that
    // very cycle must not slip through before the arm flag is registered
    assign lock_pinned = one_way && s_q.lock;

    always_comb begin
        s_d = s_q;
        if (lock_chg_ok && !lock_pinned) begin
            s_d.lock = lock_req;
        end
        if (one_way && s_d.lock) begin
            s_d.one_way_armed = 1'b1;
        end
        // Write is acknowledged either way, so software sees no fault
        if (DIS_WR_I.wr_en && !s_q.lock) begin
            s_d.regs[DIS_WR_I.idx] = DIS_WR_I.wdata;
        end
    end

    // Only reset releases an armed lock
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            s_q <= '0;
        end else if (CE_I) begin
            s_q <= s_d;
        end
    end

    assign DIS_ACK_O      = DIS_WR_I.wr_en;
    assign DIS_REGS_O     = s_q.regs;
    assign LOCK_O         = s_q.lock;
    assign ONE_WAY_HELD_O = s_q.one_way_armed;

    a_locked_no_write: assert property (@(posedge CLK_I) disable iff (RST_I)
        (CE_I && s_q.lock && DIS_WR_I.wr_en) |=> $stable(DIS_REGS_O))
        else $error("disable register changed while locked");
    a_unlocked_write: assert property (@(posedge CLK_I) disable iff (RST_I)
        (CE_I && !s_q.lock && DIS_WR_I.wr_en) |=> DIS_REGS_O[$past(DIS_WR_I.idx)]
            == $past(DIS_WR_I.wdata))
        else $error("unlocked write not stored");
    a_no_unlock_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
        (!UNLOCKED_I || !CE_I) |=> $stable(LOCK_O))
        else $error("lock changed without unlock");
    a_one_way_arm: assert property (@(posedge CLK_I) disable iff (RST_I)
        (CE_I && one_way && LOCK_O) |=> ONE_WAY_HELD_O)
        else $error("one-way lock not armed");
    a_armed_stuck: assert property (@(posedge CLK_I) disable iff (RST_I)
        ONE_WAY_HELD_O |=> LOCK_O && ONE_WAY_HELD_O)
        else $error("armed lock released without reset");
    a_armed_locked: assert property (@(posedge CLK_I) disable iff (RST_I)
        ONE_WAY_HELD_O |-> LOCK_O)
        else $error("armed without lock");
    a_free_toggle: assert property (@(posedge CLK_I) disable iff (RST_I)
        (CE_I && CFG_WR_I && UNLOCKED_I && !ONE_WAY_HELD_O && !(one_way && LOCK_O)) |=> LOCK_O
            == $past(CFG_WDATA_I[`PDWL_LOCK_BIT]))
        else $error("lock did not follow write");
    a_ack_always: assert property (@(posedge CLK_I) disable iff (RST_I)
        DIS_WR_I.wr_en |-> DIS_ACK_O)
        else $error("write not acknowledged");

    // Acknowledge only answers a real write
    a_ack_idle: assert property (@(posedge CLK_I) disable iff (RST_I)
        !DIS_WR_I.wr_en
            |-> !DIS_ACK_O)
        else $error("acknowledge without write");

    a_locked_acked: assert property (@(posedge CLK_I) disable iff (RST_I)
        (LOCK_O && DIS_WR_I.wr_en)
            |-> DIS_ACK_O)
        else $error("locked write not acknowledged");

    // Clock enable low must freeze everything
    a_freeze_regs: assert property (@(posedge CLK_I) disable iff (RST_I)
        !CE_I
            |=> $stable(DIS_REGS_O))
        else $error("disable registers moved while frozen");

    a_freeze_lock: assert property (@(posedge CLK_I) disable iff (RST_I)
        !CE_I
            |=> $stable(LOCK_O) && $stable(ONE_WAY_HELD_O))
        else $error("lock state moved while frozen");

    a_no_write_stable: assert property (@(posedge CLK_I) disable iff (RST_I)
        !DIS_WR_I.wr_en
            |=> $stable(DIS_REGS_O))
        else $error("disable registers moved without a write");

    // Lock moves only through an unlocked config write
    a_no_cfg_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
        !CFG_WR_I
            |=> $stable(LOCK_O))
        else $error("lock moved without a config write");

    a_unlock_ignored: assert property (@(posedge CLK_I) disable iff (RST_I)
        (CE_I && CFG_WR_I && !UNLOCKED_I)
            |=> $stable(LOCK_O))
        else $error("locked config write took effect");

    a_unlock_alone: assert property (@(posedge CLK_I) disable iff (RST_I)
        (UNLOCKED_I && !CFG_WR_I)
            |=> $stable(LOCK_O))
        else $error("unlock alone moved the lock");

    a_set_needs_unlock: assert property (@(posedge CLK_I) disable iff (RST_I)
        $rose(LOCK_O)
            |-> $past(CE_I && CFG_WR_I && UNLOCKED_I))
        else $error("lock set without unlocked write");

    a_clear_needs_unlock: assert property (@(posedge CLK_I) disable iff (RST_I)
        $fell(LOCK_O)
            |-> $past(CE_I && CFG_WR_I && UNLOCKED_I))
        else $error("lock cleared without unlocked write");

    a_set_takes: assert property (@(posedge CLK_I) disable iff (RST_I)
        (CE_I && CFG_WR_I && UNLOCKED_I && !ONE_WAY_HELD_O && lock_field(CFG_WDATA_I))
            |=> LOCK_O)
        else $error("unlocked set did not take");

    a_clear_takes: assert property (@(posedge CLK_I) disable iff (RST_I)
        (CE_I && CFG_WR_I && UNLOCKED_I && !one_way && !ONE_WAY_HELD_O
            && !lock_field(CFG_WDATA_I))
            |=> !LOCK_O)
        else $error("unlocked clear did not take");

    // One-way arming and what it blocks
    a_arm_on_set: assert property (@(posedge CLK_I) disable iff (RST_I)
        (CE_I && CFG_WR_I && UNLOCKED_I && one_way && lock_field(CFG_WDATA_I))
            |=> ONE_WAY_HELD_O)
        else $error("one-way set did not arm");

    a_fall_not_oneway: assert property (@(posedge CLK_I) disable iff (RST_I)
        $fell(LOCK_O)
            |-> !$past(ONE_WAY_HELD_O) && !$past(one_way))
        else $error("lock cleared under one-way mode");

    a_held_needs_oneway: assert property (@(posedge CLK_I) disable iff (RST_I)
        $rose(ONE_WAY_HELD_O)
            |-> $past(one_way))
        else $error("armed without one-way mode");

    a_held_rise_lock: assert property (@(posedge CLK_I) disable iff (RST_I)
        $rose(ONE_WAY_HELD_O)
            |-> LOCK_O)
        else $error("armed while unlocked");

    a_no_arm_free: assert property (@(posedge CLK_I) disable iff (RST_I)
        (!one_way && !ONE_WAY_HELD_O)
            |=> !ONE_WAY_HELD_O)
        else $error("armed with one-way mode off");

    a_held_ignores_unlock: assert property (@(posedge CLK_I) disable iff (RST_I)
        (ONE_WAY_HELD_O && CFG_WR_I && UNLOCKED_I)
            |=> LOCK_O && ONE_WAY_HELD_O)
        else $error("unlock acted on an armed lock");

    a_held_blocks_write: assert property (@(posedge CLK_I) disable iff (RST_I)
        (CE_I && ONE_WAY_HELD_O && DIS_WR_I.wr_en)
            |=> $stable(DIS_REGS_O))
        else $error("write landed under one-way lock");

    a_held_regs_stable: assert property (@(posedge CLK_I) disable iff (RST_I)
        ONE_WAY_HELD_O
            |=> $stable(DIS_REGS_O))
        else $error("disable registers moved while armed");

    // Arming outlives one-way mode itself; only reset drops it
    a_held_no_oneway: assert property (@(posedge CLK_I) disable iff (RST_I)
        (ONE_WAY_HELD_O && !one_way)
            |=> ONE_WAY_HELD_O)
        else $error("arm dropped with one-way mode");

    // A write must touch its own register and no other
    for (genvar g = 0; g < `PDWL_NUM_REGS; g++) begin : g_keep
        a_other_kept: assert property (@(posedge CLK_I) disable iff (RST_I)
            (!CE_I || !DIS_WR_I.wr_en || LOCK_O || (int'(DIS_WR_I.idx) != g))
                |=> $stable(DIS_REGS_O[g]))
            else $error("disable register changed without its write");
    end
endmodule // pdwl_lock

// [rtl/pdwl_defines.svh]
// Constants for the peripheral disable write lock.
// Assumes inclusion by the package and the lock module only.
// Summary of operation
// - Locked writes to disable registers complete quietly but store nothing
// - Lock bit sits at config control bit 12; one blocks, zero allows
// - Lock bit changes only after the system unlock sequence; otherwise ignored
// - One-way bit 28 of config word three stops clearing a set lock
// - Under one-way lock, unlock has no effect; disable registers stay unwritable
// - Only device reset clears a one-way lock
`ifndef PDWL_DEFINES_SVH
`define PDWL_DEFINES_SVH
`define PDWL_LOCK_BIT      12
`define PDWL_ONE_WAY_BIT   28
`define PDWL_NUM_REGS      8
`define PDWL_IDX_W         3
`define PDWL_DATA_W        32
`define PDWL_DISABLE_RST   32'h0000_0000
`endif

// [rtl/pdwl_pkg.sv]
// Types for the peripheral disable write lock.
// Assumes pdwl_defines.svh is on the include path.
`include "pdwl_defines.svh"
package pdwl_pkg;
    typedef struct packed {
        logic                     wr_en;
        logic [`PDWL_IDX_W-1:0]   idx;
        logic [`PDWL_DATA_W-1:0]  wdata;
    } pdwl_wr_t;

    typedef struct packed {
        logic [`PDWL_NUM_REGS-1:0][`PDWL_DATA_W-1:0] regs;
        logic                                        lock;
        logic                                        one_way_armed;
    } pdwl_state_t;
endpackage

// [tb/test_peripheral_disable_write_lock.sv]
// Bench for the disable register lock: a free session, then a one-way session, then a clock-enable hold session.
// Assumes pdwl_pkg is compiled first; the unlock level is driven here directly.
`timescale 1ns/1ps
module test_peripheral_disable_write_lock;
    import pdwl_pkg::*;
    logic                  clk = 0, rst = 1, ce = 1, unl = 0, cwr = 0, ack, lock, held;
    logic [31:0]           cw3 = 0, cwd = 0;
    pdwl_wr_t              dw = '0;
    logic [7:0][31:0]      regs;
    int                    err_count = 0, cmp_count = 0;
    always #2.5 clk = ~clk;
    pdwl_lock uut (.CLK_I(clk), .RST_I(rst), .CE_I(ce), .CFG_WORD3_I(cw3), .UNLOCKED_I(unl),
        .CFG_WR_I(cwr), .CFG_WDATA_I(cwd), .DIS_WR_I(dw), .DIS_ACK_O(ack),
        .DIS_REGS_O(regs), .LOCK_O(lock), .ONE_WAY_HELD_O(held));
    task chk(string n, logic [31:0] s, logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    // Extra edge at the end keeps the strobe low for a cycle between requests
    task cfg(logic u, logic v);
        @(posedge clk);
        unl <= u;
        cwr <= 1'b1;
        cwd <= {19'h0, v, 12'h0};
        @(posedge clk);
        cwr <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task dwr(logic [2:0] i, logic [31:0] d);
        @(posedge clk);
        dw <= {1'b1, i, d};
        #1 chk("ack", 32'(ack), 32'h1);
        @(posedge clk);
        dw.wr_en <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task t_free();
        dwr(3'h0, 32'hA5A5_0001);
        chk("reg0", regs[0], 32'hA5A5_0001);
        cfg(1'b1, 1'b1);
        chk("lock set", 32'(lock), 32'h1);
        dwr(3'h7, 32'h1234_5678);
        chk("reg7 locked", regs[7], 32'h0);
        cfg(1'b0, 1'b0);
        chk("lock no unlock", 32'(lock), 32'h1);
        cfg(1'b1, 1'b0);
        chk("lock clear", 32'(lock), 32'h0);
        dwr(3'h7, 32'h1234_5678);
        chk("reg7 open", regs[7], 32'h1234_5678);
    endtask
    task t_oneway();
        cfg(1'b1, 1'b1);
        @(posedge clk);
        cw3 <= 32'h1000_0000;
        @(posedge clk);
        #1;
        chk("late arm", 32'(held), 32'h1);
        cfg(1'b1, 1'b0);
        chk("late lock kept", 32'(lock), 32'h1);
        do_reset();
        chk("held after reset", 32'(held), 32'h0);
        cfg(1'b1, 1'b1);
        chk("held", 32'(held), 32'h1);
        cfg(1'b1, 1'b0);
        chk("lock kept", 32'(lock), 32'h1);
        dwr(3'h2, 32'hFFFF_FFFF);
        chk("reg2 held", regs[2], 32'h0);
        do_reset();
        chk("lock after reset", 32'(lock), 32'h0);
        dwr(3'h2, 32'hFFFF_FFFF);
        chk("reg2 after reset", regs[2], 32'hFFFF_FFFF);
    endtask
    // Clock enable low must freeze writes and the lock alike
    task t_hold();
        @(posedge clk);
        ce <= 1'b0;
        dwr(3'h3, 32'h0BAD_F00D);
        chk("reg3 frozen", regs[3], 32'h0);
        cfg(1'b1, 1'b1);
        chk("lock frozen", 32'(lock), 32'h0);
        @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        #1;
    endtask
    task final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // All three sessions need well under a hundred cycles
    initial begin
        #2000;
        err_count++;
        final_report();
    end
    initial begin
        do_reset();
        t_free();
        t_oneway();
        t_hold();
        final_report();
    end
endmodule // test_peripheral_disable_write_lock
